// *** core/pil_pkg.sv ***
// Purpose: shared constants and types of the power and init word loader
// Assumes: 32-bit AXI4-Lite register bus, 16-bit configuration words
// Notes:   register offsets are byte addresses, one aligned word each
package pil_pkg;
   localparam int AXI_AW = 8;

   typedef struct packed {
      logic [AXI_AW-1:0] awaddr;
      logic              awvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              wvalid;
      logic              bready;
      logic [AXI_AW-1:0] araddr;
      logic              arvalid;
      logic              rready;
   } pil_axi_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pil_axi_rsp_s;

   typedef enum logic [2:0] {
      PIL_ST_IDLE, PIL_ST_REQ_PWR, PIL_ST_WAIT_PWR, PIL_ST_REQ_INIT, PIL_ST_WAIT_INIT, PIL_ST_DONE
   } pil_state_e;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // configuration word addresses in the non-volatile store
   localparam logic [7:0] NVM_PWR_WORD  = 8'h22;
   localparam logic [7:0] NVM_INIT_WORD = 8'h24;
   localparam logic [15:0] PWR_WORD_DEFAULT  = 16'h0000;
   localparam logic [15:0] INIT_WORD_DEFAULT = 16'h0280;

   // power word fields
   localparam int PWR_D0_HI = 15;
   localparam int PWR_D0_LO = 8;
   localparam int PWR_CF_HI = 7;
   localparam int PWR_CF_LO = 5;
   localparam int PWR_D3_HI = 4;
   localparam int PWR_D3_LO = 0;
   localparam int PWR_UNIT_MW = 100;

   // power data selector codes
   localparam logic [3:0] SEL_D0_A   = 4'h0;
   localparam logic [3:0] SEL_D0_B   = 4'h4;
   localparam logic [3:0] SEL_D3_A   = 4'h3;
   localparam logic [3:0] SEL_D3_B   = 4'h7;
   localparam logic [3:0] SEL_COMMON = 4'h8;

   // initialization word fields
   localparam int INIT_LOS_INV = 13;
   localparam int INIT_WAKE_EN  = 10;
   localparam int INIT_MDIX     = 9;
   localparam int INIT_ROM_DIS  = 7;
   localparam int INIT_WAKE_ANY = 6;
   localparam int INIT_LINK_HI = 5;
   localparam int INIT_LINK_LO = 4;

   // register map and bit positions
   localparam logic [AXI_AW-1:0] OFF_CTRL      = 8'h00;
   localparam logic [AXI_AW-1:0] OFF_WAKE_CTRL = 8'h04;
   localparam logic [AXI_AW-1:0] OFF_CTRL_EXT  = 8'h08;
   localparam logic [AXI_AW-1:0] OFF_PHY_CFG   = 8'h0C;
   localparam logic [AXI_AW-1:0] OFF_PM_SEL    = 8'h10;
   localparam logic [AXI_AW-1:0] OFF_PM_DATA   = 8'h14;
   localparam logic [AXI_AW-1:0] OFF_STATUS    = 8'h18;
   localparam logic [AXI_AW-1:0] OFF_NVM_WORDS = 8'h1C;
   localparam int CTRL_LOS_BIT   = 7;
   localparam int CTRL_WAKE_BIT  = 6;
   localparam int WAKE_EN_BIT    = 0;
   localparam int WAKE_ANY_BIT   = 5;
   localparam int EXT_LINK_HI    = 23;
   localparam int EXT_LINK_LO    = 22;
   localparam int PHY_MDIX_BIT   = 0;
   localparam int ST_DONE_BIT    = 0;
   localparam int ST_PWR_HIT_BIT = 1;
   localparam int ST_INIT_HIT_BIT = 2;
   localparam int ST_ROM_DIS_BIT = 3;
endpackage : pil_pkg

// *** core/pil_loader.sv ***
// Purpose: loads the power and initialization words after reset and exposes the result
// Assumes: storage answers each read with one ack pulse; bus is AXI4-Lite, one clock
// Notes:   fields only live in byte lanes 0 and 2; other strobes are ignored
//
// What this block does
// - selector 0 or 4 returns power word bits 15:8, the D0 figure.
// - selector 3 or 7 returns power word bits 4:0, the D3 figure.
// - selector 8 returns power word bits 7:5, the common-function figure.
// - D0 and D3 counts are reported in 100 mW steps.
// - unused upper bits of a reported power figure read as zero.
// - init bit 13 sets the reset value of the signal-loss invert control bit.
// - init bit 10 goes to both control bit 6 and wake control bit 0.
// - init bit 9, default one, loads PHY configuration bit 0.
// - with auto crossover on, the device itself picks the pair swap.
// - init bit 7 set disables the expansion ROM base address register.
// - init bit 6: zero wakes only in D3, one wakes in any state.
// - init bits 5:4 load the link interface select; 00 means internal copper.
`timescale 1ns/1ps
module pil_loader (
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire pil_pkg::pil_axi_req_s axi_req,
   output pil_pkg::pil_axi_rsp_s     axi_rsp,
   output logic                      nvm_rd_req,
   output logic [7:0]                nvm_rd_addr,
   input  wire logic                 nvm_rd_ack,
   input  wire logic                 nvm_rd_hit,
   input  wire logic [15:0]          nvm_rd_data,
   input  wire logic                 fn_in_d3,
   output logic                      load_done,
   output logic                      loss_signal_invert,
   output logic                      ctrl_power_wake_en,
   output logic                      advanced_power_wake_enable,
   output logic                      power_wake_in_full_power,
   output logic                      power_wake_allowed,
   output logic [1:0]                link_interface_select,
   output logic                      auto_crossover_en,
   output logic                      exp_rom_bar_disable
);
   import pil_pkg::*;

   pil_state_e    state_reg;
   logic [15:0]   pwr_word_reg;
   logic [15:0]   init_word_reg;
   logic          pwr_hit_reg;
   logic          init_hit_reg;
   logic [3:0]    pm_sel_reg;
   logic [7:0]    pm_data_reg;
   pil_axi_rsp_s  rsp_reg;
   logic          aw_full_reg;
   logic          w_full_reg;
   logic [AXI_AW-1:0] wr_addr_reg;
   logic [31:0]   wr_data_reg;
   logic [3:0]    wr_strb_reg;
   logic [15:0]   init_word_next;
   logic          load_init;
   logic          wr_fire;
   logic [31:0]   rd_word;
   logic          rd_ok;

   // power figure returned for a selector; narrow fields are zero padded
   function automatic logic [7:0] pm_value(input logic [3:0] sel, input logic [15:0] pw);
      logic [7:0] v;
      v = 8'h00;
      case (sel)
         SEL_D0_A, SEL_D0_B: v = pw[PWR_D0_HI:PWR_D0_LO];
         SEL_D3_A, SEL_D3_B: v = {3'h0, pw[PWR_D3_HI:PWR_D3_LO]};
         SEL_COMMON:         v = {5'h00, pw[PWR_CF_HI:PWR_CF_LO]};
         default:            v = 8'h00;
      endcase
      return v;
   endfunction : pm_value

   function automatic logic hit(input logic [AXI_AW-1:0] a, input logic [AXI_AW-1:0] off);
      return a == off;
   endfunction : hit

   // loader sequence
   assign load_init      = (state_reg == PIL_ST_WAIT_INIT) && nvm_rd_ack;
   assign init_word_next = nvm_rd_hit ? nvm_rd_data : INIT_WORD_DEFAULT;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_reg   <= PIL_ST_IDLE;
         nvm_rd_req  <= 1'b0;
         nvm_rd_addr <= 8'h00;
      end else begin
         nvm_rd_req <= 1'b0;
         case (state_reg)
            PIL_ST_IDLE: state_reg <= PIL_ST_REQ_PWR;
            PIL_ST_REQ_PWR: begin
               nvm_rd_req  <= 1'b1;
               nvm_rd_addr <= NVM_PWR_WORD;
               state_reg   <= PIL_ST_WAIT_PWR;
            end
            PIL_ST_WAIT_PWR: if (nvm_rd_ack) state_reg <= PIL_ST_REQ_INIT;
            PIL_ST_REQ_INIT: begin
               nvm_rd_req  <= 1'b1;
               nvm_rd_addr <= NVM_INIT_WORD;
               state_reg   <= PIL_ST_WAIT_INIT;
            end
            PIL_ST_WAIT_INIT: if (nvm_rd_ack) state_reg <= PIL_ST_DONE;
            PIL_ST_DONE: state_reg <= PIL_ST_DONE;
            default: state_reg <= PIL_ST_IDLE;
         endcase
      end
   end

   // captured words; a miss keeps the default image
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pwr_word_reg  <= PWR_WORD_DEFAULT;
         init_word_reg <= INIT_WORD_DEFAULT;
         pwr_hit_reg   <= 1'b0;
         init_hit_reg  <= 1'b0;
         load_done     <= 1'b0;
      end else begin
         if ((state_reg == PIL_ST_WAIT_PWR) && nvm_rd_ack) begin
            pwr_word_reg <= nvm_rd_hit ? nvm_rd_data : PWR_WORD_DEFAULT;
            pwr_hit_reg  <= nvm_rd_hit;
         end
         if (load_init) begin
            init_word_reg <= init_word_next;
            init_hit_reg  <= nvm_rd_hit;
            load_done     <= 1'b1;
         end
      end
   end

   // AXI4-Lite handshakes; one process owns every response flop of the bus
   assign wr_fire = aw_full_reg && w_full_reg && !rsp_reg.bvalid;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         aw_full_reg     <= 1'b0;
         w_full_reg      <= 1'b0;
         wr_addr_reg     <= '0;
         wr_data_reg     <= 32'h0000_0000;
         wr_strb_reg     <= 4'h0;
         rsp_reg.awready <= 1'b1;
         rsp_reg.wready  <= 1'b1;
         rsp_reg.bvalid  <= 1'b0;
         rsp_reg.bresp   <= RESP_OKAY;
         rsp_reg.arready <= 1'b1;
         rsp_reg.rvalid  <= 1'b0;
         rsp_reg.rdata   <= 32'h0000_0000;
         rsp_reg.rresp   <= RESP_OKAY;
      end else begin
         if (axi_req.awvalid && rsp_reg.awready) begin
            aw_full_reg     <= 1'b1;
            wr_addr_reg     <= axi_req.awaddr;
            rsp_reg.awready <= 1'b0;
         end
         if (axi_req.wvalid && rsp_reg.wready) begin
            w_full_reg     <= 1'b1;
            wr_data_reg    <= axi_req.wdata;
            wr_strb_reg    <= axi_req.wstrb;
            rsp_reg.wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_full_reg    <= 1'b0;
            w_full_reg     <= 1'b0;
            rsp_reg.bvalid <= 1'b1;
            rsp_reg.bresp  <= (wr_addr_reg[1:0] == 2'h0 && wr_addr_reg <= OFF_NVM_WORDS) ? RESP_OKAY : RESP_SLVERR;
         end
         if (rsp_reg.bvalid && axi_req.bready) begin
            // one write in flight: channels reopen only once the answer is taken
            rsp_reg.bvalid  <= 1'b0;
            rsp_reg.awready <= 1'b1;
            rsp_reg.wready  <= 1'b1;
         end
         if (axi_req.arvalid && rsp_reg.arready) begin
            rsp_reg.arready <= 1'b0;
            rsp_reg.rvalid  <= 1'b1;
            rsp_reg.rdata   <= rd_word;
            rsp_reg.rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (rsp_reg.rvalid && axi_req.rready) begin
            rsp_reg.rvalid  <= 1'b0;
            rsp_reg.arready <= 1'b1;
         end
      end
   end

   // device registers
   // a load completing in the same cycle as a write overrides it
   always_ff @(posedge clk) begin
      if (!rstn) begin
         loss_signal_invert         <= INIT_WORD_DEFAULT[INIT_LOS_INV];
         ctrl_power_wake_en         <= INIT_WORD_DEFAULT[INIT_WAKE_EN];
         advanced_power_wake_enable <= INIT_WORD_DEFAULT[INIT_WAKE_EN];
         power_wake_in_full_power   <= INIT_WORD_DEFAULT[INIT_WAKE_ANY];
         link_interface_select      <= INIT_WORD_DEFAULT[INIT_LINK_HI:INIT_LINK_LO];
         auto_crossover_en          <= INIT_WORD_DEFAULT[INIT_MDIX];
         exp_rom_bar_disable        <= INIT_WORD_DEFAULT[INIT_ROM_DIS];
         pm_sel_reg                 <= 4'h0;
      end else if (load_init) begin
         loss_signal_invert         <= init_word_next[INIT_LOS_INV];
         ctrl_power_wake_en         <= init_word_next[INIT_WAKE_EN];
         advanced_power_wake_enable <= init_word_next[INIT_WAKE_EN];
         power_wake_in_full_power   <= init_word_next[INIT_WAKE_ANY];
         link_interface_select      <= init_word_next[INIT_LINK_HI:INIT_LINK_LO];
         auto_crossover_en          <= init_word_next[INIT_MDIX];
         exp_rom_bar_disable        <= init_word_next[INIT_ROM_DIS];
      end else if (wr_fire) begin
         if (hit(wr_addr_reg, OFF_CTRL) && wr_strb_reg[0]) begin
            loss_signal_invert <= wr_data_reg[CTRL_LOS_BIT];
            ctrl_power_wake_en <= wr_data_reg[CTRL_WAKE_BIT];
         end
         if (hit(wr_addr_reg, OFF_WAKE_CTRL) && wr_strb_reg[0]) begin
            advanced_power_wake_enable <= wr_data_reg[WAKE_EN_BIT];
            power_wake_in_full_power   <= wr_data_reg[WAKE_ANY_BIT];
         end
         if (hit(wr_addr_reg, OFF_CTRL_EXT) && wr_strb_reg[2])
            link_interface_select <= wr_data_reg[EXT_LINK_HI:EXT_LINK_LO];
         if (hit(wr_addr_reg, OFF_PHY_CFG) && wr_strb_reg[0])
            auto_crossover_en <= wr_data_reg[PHY_MDIX_BIT];
         if (hit(wr_addr_reg, OFF_PM_SEL) && wr_strb_reg[0])
            pm_sel_reg <= wr_data_reg[3:0];
      end
   end

   // power data follows the selector one cycle later
   always_ff @(posedge clk) begin
      if (!rstn) pm_data_reg <= 8'h00;
      else       pm_data_reg <= pm_value(pm_sel_reg, pwr_word_reg);
   end

   // wake from full power only when allowed; otherwise D3 only
   always_ff @(posedge clk) begin
      if (!rstn) power_wake_allowed <= 1'b0;
      else power_wake_allowed <= advanced_power_wake_enable && (power_wake_in_full_power || fn_in_d3);
   end

   // read data decode, taken by the response flops when the address is accepted
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      case (axi_req.araddr)
         OFF_CTRL: begin
            rd_word[CTRL_LOS_BIT] = loss_signal_invert;
            rd_word[CTRL_WAKE_BIT] = ctrl_power_wake_en;
         end
         OFF_WAKE_CTRL: begin
            rd_word[WAKE_EN_BIT]  = advanced_power_wake_enable;
            rd_word[WAKE_ANY_BIT] = power_wake_in_full_power;
         end
         OFF_CTRL_EXT: rd_word[EXT_LINK_HI:EXT_LINK_LO] = link_interface_select;
         OFF_PHY_CFG:  rd_word[PHY_MDIX_BIT] = auto_crossover_en;
         OFF_PM_SEL:   rd_word[3:0] = pm_sel_reg;
         OFF_PM_DATA:  rd_word[7:0] = pm_data_reg;
         OFF_STATUS: begin
            rd_word[ST_DONE_BIT]     = load_done;
            rd_word[ST_PWR_HIT_BIT]  = pwr_hit_reg;
            rd_word[ST_INIT_HIT_BIT] = init_hit_reg;
            rd_word[ST_ROM_DIS_BIT]  = exp_rom_bar_disable;
         end
         OFF_NVM_WORDS: rd_word = {init_word_reg, pwr_word_reg};
         default: rd_ok = 1'b0;
      endcase
   end

   assign axi_rsp = rsp_reg;

   // checks
   default clocking pil_cb @(posedge clk); endclocking
   default disable iff (!rstn);

   chk_d0_power_report: assert property (
      (pm_sel_reg == SEL_D0_A || pm_sel_reg == SEL_D0_B) |=> pm_data_reg == $past(pwr_word_reg[15:8]))
      else $error("d0 power figure not reported");
   chk_d3_power_report: assert property (
      (pm_sel_reg == SEL_D3_A || pm_sel_reg == SEL_D3_B) |=> pm_data_reg == {3'h0, $past(pwr_word_reg[4:0])})
      else $error("d3 power figure not reported");
   chk_common_power_pad: assert property (
      pm_sel_reg == SEL_COMMON |=> pm_data_reg == {5'h00, $past(pwr_word_reg[7:5])})
      else $error("common power figure wrong or not zero padded");
   chk_los_invert_load: assert property (
      $rose(load_done) |-> loss_signal_invert == init_word_reg[13])
      else $error("signal loss invert not loaded");
   chk_wake_enable_copy: assert property (
      $rose(load_done) |-> ctrl_power_wake_en == init_word_reg[10] && advanced_power_wake_enable == init_word_reg[10])
      else $error("wake enable copies disagree with init word");
   chk_crossover_load: assert property (
      $rose(load_done) |-> auto_crossover_en == init_word_reg[9])
      else $error("crossover default not loaded");
   chk_rom_bar_load: assert property (
      $rose(load_done) |-> exp_rom_bar_disable == init_word_reg[7] ##1 exp_rom_bar_disable == $past(exp_rom_bar_disable))
      else $error("rom bar disable not loaded or not held");
   chk_wake_d3_gate: assert property (
      advanced_power_wake_enable && !power_wake_in_full_power && !fn_in_d3 |=> !power_wake_allowed)
      else $error("wake allowed outside d3");
   chk_link_select_load: assert property (
      $rose(load_done) |-> link_interface_select == init_word_reg[5:4])
      else $error("link select not loaded");
   chk_missing_word_default: assert property (
      load_init && !nvm_rd_hit |=> init_word_reg == INIT_WORD_DEFAULT && auto_crossover_en && exp_rom_bar_disable)
      else $error("missing init word did not restore defaults");

   cov_load_with_words: cover property (load_init && nvm_rd_hit && pwr_hit_reg);
   cov_load_missing:    cover property (load_init && !nvm_rd_hit);
   cov_common_read:     cover property (pm_sel_reg == SEL_COMMON ##1 rsp_reg.rvalid);
   cov_wake_any_state:  cover property (power_wake_allowed && !fn_in_d3);
endmodule : pil_loader

// *** verification/pil_nvm_model.sv ***
// Purpose: behavioural store of the two configuration words read by the loader
// Assumes: one read pending at a time; answer comes latency+2 cycles after a request
// Notes:   between answers data and hit toggle so a stale word never looks valid
`timescale 1ns/1ps
module pil_nvm_model (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        nvm_rd_req,
   input  wire logic [7:0]  nvm_rd_addr,
   input  wire logic [15:0] pwr_word,
   input  wire logic [15:0] init_word,
   input  wire logic [1:0]  word_hit,
   input  wire logic [4:0]  latency,
   output logic             nvm_rd_ack,
   output logic             nvm_rd_hit,
   output logic [15:0]      nvm_rd_data
);
   import pil_pkg::*;
   logic [4:0] wait_reg;
   logic       busy_reg;
   logic [7:0] addr_reg;

   always_ff @(posedge clk) begin
      nvm_rd_ack  <= 1'b0;
      nvm_rd_data <= ~nvm_rd_data;
      nvm_rd_hit  <= ~nvm_rd_hit;
      if (!rstn) begin
         busy_reg    <= 1'b0;
         nvm_rd_data <= 16'h5A5A;
      end else if (nvm_rd_req) begin
         busy_reg <= 1'b1;
         wait_reg <= latency;
         addr_reg <= nvm_rd_addr;
      end else if (busy_reg && wait_reg == 5'h0) begin
         busy_reg    <= 1'b0;
         nvm_rd_ack  <= 1'b1;
         // an unknown address answers with a miss and garbage
         nvm_rd_hit  <= (addr_reg == NVM_PWR_WORD) ? word_hit[0] : (addr_reg == NVM_INIT_WORD) & word_hit[1];
         nvm_rd_data <= (addr_reg == NVM_PWR_WORD) ? pwr_word : (addr_reg == NVM_INIT_WORD) ? init_word : 16'hDEAD;
      end else if (busy_reg) begin
         wait_reg <= wait_reg - 5'h1;
      end
   end
endmodule : pil_nvm_model

// *** verification/pil_loader_tb_top.sv ***
// Purpose: self-checking bench of the power and init word loader
// Assumes: 200 MHz clock, synchronous active-low reset, bench is the AXI4-Lite master
// Notes:   every test reloads new words; control register reads are masked to the loaded fields, PM data reads are compared whole
`timescale 1ns/1ps
module pil_loader_tb_top;
   import pil_pkg::*;
   logic         clk;
   logic         rstn;
   pil_axi_req_s axi_req;
   pil_axi_rsp_s axi_rsp;
   logic         nvm_rd_req, nvm_rd_ack, nvm_rd_hit, fn_in_d3, load_done, loss_signal_invert;
   logic         ctrl_power_wake_en, advanced_power_wake_enable, power_wake_in_full_power;
   logic         power_wake_allowed, auto_crossover_en, exp_rom_bar_disable;
   logic [1:0]   link_interface_select, hit;
   logic [7:0]   nvm_rd_addr;
   logic [15:0]  nvm_rd_data, pw, iw, ep, ei;
   logic [4:0]   lat;
   logic [31:0]  seed = 32'h0001_4179;
   logic [31:0]  d;
   logic [1:0]   r;
   int           err_total, checks_done, cyc;

   pil_loader i_pil_loader (.clk(clk), .rstn(rstn), .axi_req(axi_req), .axi_rsp(axi_rsp),
      .nvm_rd_req(nvm_rd_req), .nvm_rd_addr(nvm_rd_addr), .nvm_rd_ack(nvm_rd_ack),
      .nvm_rd_hit(nvm_rd_hit), .nvm_rd_data(nvm_rd_data), .fn_in_d3(fn_in_d3), .load_done(load_done),
      .loss_signal_invert(loss_signal_invert), .ctrl_power_wake_en(ctrl_power_wake_en),
      .advanced_power_wake_enable(advanced_power_wake_enable),
      .power_wake_in_full_power(power_wake_in_full_power), .power_wake_allowed(power_wake_allowed),
      .link_interface_select(link_interface_select), .auto_crossover_en(auto_crossover_en),
      .exp_rom_bar_disable(exp_rom_bar_disable));

   pil_nvm_model i_pil_nvm_model (.clk(clk), .rstn(rstn), .nvm_rd_req(nvm_rd_req),
      .nvm_rd_addr(nvm_rd_addr), .pwr_word(pw), .init_word(iw), .word_hit(hit), .latency(lat),
      .nvm_rd_ack(nvm_rd_ack), .nvm_rd_hit(nvm_rd_hit), .nvm_rd_data(nvm_rd_data));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic [31:0] pm_exp(input logic [3:0] s, input logic [15:0] p);
      case (s)
         SEL_D0_A, SEL_D0_B: return {24'h0, p[15:8]};
         SEL_D3_A, SEL_D3_B: return {27'h0, p[4:0]};
         SEL_COMMON:         return {29'h0, p[7:5]};
         default:            return 32'h0;
      endcase
   endfunction : pm_exp

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic axw(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] resp);
      axi_req.awaddr  <= a;
      axi_req.awvalid <= 1'b1;
      axi_req.wdata   <= wd;
      axi_req.wstrb   <= 4'hF;
      axi_req.wvalid  <= 1'b1;
      axi_req.bready  <= 1'b1;
      do begin
         @(posedge clk);
         if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
         if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      end while (axi_rsp.bvalid !== 1'b1);
      resp = axi_rsp.bresp;
      axi_req.bready <= 1'b0;
      @(posedge clk);
   endtask : axw

   task automatic rd(input logic [7:0] a, output logic [31:0] rdat, output logic [1:0] resp);
      axi_req.araddr  <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready  <= 1'b1;
      do begin
         @(posedge clk);
         if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      end while (axi_rsp.rvalid !== 1'b1);
      rdat = axi_rsp.rdata;
      resp = axi_rsp.rresp;
      axi_req.rready <= 1'b0;
      @(posedge clk);
   endtask : rd

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   // ceiling is over ten times the expected run of about 2000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         finish_test();
      end
   end

   initial begin
      rstn = 1'b0;
      axi_req = '0;
      fn_in_d3 = 1'b0;
      {pw, iw, hit, lat} = '0;
      for (int n = 0; n < 8; n++) begin
         @(posedge clk);
         // words describe an enabled port, so the wake enable may be set
         d = xs();
         pw  <= (n == 1) ? 16'hFFFF : d[15:0];
         iw  <= (n == 1) ? 16'h26F0 : d[31:16] & 16'h26F0;
         d = xs();
         hit <= (n == 0) ? 2'b00 : (n == 1) ? 2'b11 : d[1:0];
         lat <= (n == 1) ? 5'h1F : d[6:2];
         rstn <= 1'b0;
         repeat (16) @(posedge clk);
         chk({auto_crossover_en, exp_rom_bar_disable, loss_signal_invert, load_done}, 32'hC);
         rstn <= 1'b1;
         for (int i = 0; i < 300 && load_done !== 1'b1; i++) @(posedge clk);
         @(posedge clk);
         ep = hit[0] ? pw : PWR_WORD_DEFAULT;
         ei = hit[1] ? iw : INIT_WORD_DEFAULT;
         chk(load_done, 1'b1);
         chk(loss_signal_invert, ei[13]);
         chk({ctrl_power_wake_en, advanced_power_wake_enable}, {2{ei[10]}});
         chk(auto_crossover_en, ei[9]);
         chk(exp_rom_bar_disable, ei[7]);
         chk(power_wake_in_full_power, ei[6]);
         chk(link_interface_select, ei[5:4]);
         rd(OFF_CTRL, d, r);
         chk(d & 32'hC0, {ei[13], ei[10], 6'h0});
         rd(OFF_WAKE_CTRL, d, r);
         chk(d & 32'h21, {ei[6], 4'h0, ei[10]});
         rd(OFF_CTRL_EXT, d, r);
         chk(d[23:22], ei[5:4]);
         rd(OFF_PHY_CFG, d, r);
         chk(d[0], ei[9]);
         rd(OFF_STATUS, d, r);
         chk(d[3:0], {ei[7], hit, 1'b1});
         rd(OFF_NVM_WORDS, d, r);
         chk(d, {ei, ep});
         for (int v = 0; v < 2; v++) begin
            fn_in_d3 <= v[0];
            repeat (3) @(posedge clk);
            chk(power_wake_allowed, ei[10] & (ei[6] | v[0]));
         end
         for (int s = 0; s < 16; s++) begin
            axw(OFF_PM_SEL, s, r);
            rd(OFF_PM_DATA, d, r);
            chk(d, pm_exp(s[3:0], ep));
         end
         axw(OFF_PHY_CFG, {31'h0, ~ei[9]}, r);
         chk(r, RESP_OKAY);
         chk(auto_crossover_en, {31'h0, ~ei[9]});
         // software writes after the load, wake enables written apart
         d = xs();
         axw(OFF_CTRL, d, r);
         axw(OFF_WAKE_CTRL, ~d, r);
         axw(OFF_CTRL_EXT, d, r);
         chk({loss_signal_invert, ctrl_power_wake_en}, d[7:6]);
         chk({advanced_power_wake_enable, power_wake_in_full_power}, {~d[0], ~d[5]});
         chk(link_interface_select, d[23:22]);
         chk(exp_rom_bar_disable, ei[7]);
         axw(OFF_PM_DATA, 32'hFFFF_FFFF, r);
         chk(r, RESP_OKAY);
         rd(OFF_PM_DATA, d, r);
         chk(d, pm_exp(4'hF, ep));
         axw(8'h20, 32'h1, r);
         chk(r, RESP_SLVERR);
         rd(8'h20, d, r);
         chk(d, 32'h0);
         chk(r, RESP_SLVERR);
         rd(8'h02, d, r);
         chk(r, RESP_SLVERR);
         $display("test %0d done, hit %b, latency %0d", n, hit, lat);
      end
      finish_test();
   end
endmodule : pil_loader_tb_top
